// File: hdl/dor_key_if.sv
`timescale 1ns/10ps
interface dor_key_if;
	logic [23:0] pixel;
	logic [3:0]  cspace;
	logic [15:0] lim_red;
	logic [15:0] lim_green;
	logic [15:0] lim_blue;
	logic        match;
	modport src (output pixel, cspace, lim_red, lim_green, lim_blue, input match);
	modport chk (input pixel, cspace, lim_red, lim_green, lim_blue, output match);
endinterface : dor_key_if

// File: hdl/dor_key_match.sv
`timescale 1ns/10ps
module dor_key_match (
	// compare port
	dor_key_if.chk kif
);
	import dor_pkg::*;

	// ---------------------------------------------------------------
	// channel split and window test
	// ---------------------------------------------------------------
	function automatic logic [23:0] split(input logic [3:0] cs, input logic [23:0] p);
		logic [23:0] c;
		c = 24'h000000;
		unique case (cs)
			CS_RGB111:  c = {7'h00, p[2], 7'h00, p[1], 7'h00, p[0]};
			CS_RGB222:  c = {6'h00, p[5:4], 6'h00, p[3:2], 6'h00, p[1:0]};
			CS_RGB8BPP: c = {5'h00, p[7:5], 5'h00, p[4:2], 6'h00, p[1:0]};
			CS_RGB333:  c = {5'h00, p[8:6], 5'h00, p[5:3], 5'h00, p[2:0]};
			CS_RGB444:  c = {4'h0, p[11:8], 4'h0, p[7:4], 4'h0, p[3:0]};
			CS_RGB555:  c = {3'h0, p[15:11], 3'h0, p[10:6], 3'h0, p[4:0]};
			CS_RGB565:  c = {3'h0, p[15:11], 2'h0, p[10:5], 3'h0, p[4:0]};
			CS_RGB666:  c = {2'h0, p[17:12], 2'h0, p[11:6], 2'h0, p[5:0]};
			CS_RGB888:  c = p;
			default:    c = p;
		endcase
		return c;
	endfunction : split

	function automatic logic inside_lim(input logic [7:0] v, input logic [15:0] lim);
		return (v >= lim[7:0]) && (v <= lim[15:8]);
	endfunction : inside_lim

	logic [23:0] chan;

	assign chan      = split(kif.cspace, kif.pixel);
	assign kif.match = inside_lim(chan[23:16], kif.lim_red)
		&& inside_lim(chan[15:8], kif.lim_green)
		&& inside_lim(chan[7:0], kif.lim_blue);
endmodule : dor_key_match

// File: hdl/dor_output_stage.sv
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// - analog pins drive only in single scan analog, or twin with serial formats
// - analog pins float whenever converter output enable is clear
// - line, frame, reference sync pins carry mixers 0, 1 and 2
// - sync pins pass any mixer waveform without fixed function
// - mixers 3 to 7 appear on data pin bits 19 to 23
// - mixer 7 gates the pixel clock internally
// - mixer 6 sets the display sync flag software can poll
// - mixer 5 feeds the backlight lamp driver synchronisation
// - internal mixer connections hold regardless of display configuration
// - key match pin carries key result, floats when its enable clear
// - key asserts with chosen polarity for visible pixels inside limits
// - key stays inactive throughout blanking
// - one pixel per clock: key updates every pixel clock
// - several pixels per clock: key follows leftmost complete pixel
// - no complete pixel: key keeps previous leftmost complete pixel
// - match needs lower <= value <= upper on all three channels
// - channels split automatically by configured colour space
// - data bits 23:19 carry pixels only in 24-bit serial or analog twin
// - every pin group has its own output enable; only the analog codes are also forced to zero when it is clear
module dor_output_stage #(
	parameter int ADDR_W = dor_pkg::AXI_AW
) (
	// clock and reset
	input  wire logic                        REF_CLK,
	input  wire logic                        RST_N,
	// register bus
	input  wire logic [ADDR_W-1:0]           S_AXI_AWADDR,
	input  wire logic                        S_AXI_AWVALID,
	output      logic                        S_AXI_AWREADY,
	input  wire logic [dor_pkg::AXI_DW-1:0]  S_AXI_WDATA,
	input  wire logic [3:0]                  S_AXI_WSTRB,
	input  wire logic                        S_AXI_WVALID,
	output      logic                        S_AXI_WREADY,
	output      logic [1:0]                  S_AXI_BRESP,
	output      logic                        S_AXI_BVALID,
	input  wire logic                        S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0]           S_AXI_ARADDR,
	input  wire logic                        S_AXI_ARVALID,
	output      logic                        S_AXI_ARREADY,
	output      logic [dor_pkg::AXI_DW-1:0]  S_AXI_RDATA,
	output      logic [1:0]                  S_AXI_RRESP,
	output      logic                        S_AXI_RVALID,
	input  wire logic                        S_AXI_RREADY,
	// pixel pipeline
	input  wire logic                        PIX_CLK,
	input  wire logic [23:0]                 PIX_DATA,
	input  wire logic [23:0]                 PIX_KEY_DATA,
	input  wire logic                        PIX_VISIBLE,
	input  wire logic                        PIX_COMPLETE,
	input  wire logic [7:0]                  ANA_RED_IN,
	input  wire logic [7:0]                  ANA_GREEN_IN,
	input  wire logic [7:0]                  ANA_BLUE_IN,
	input  wire logic [7:0]                  SYNC_MIX,
	// analog colour pins
	output      logic [7:0]                  ANA_RED,
	output      logic [7:0]                  ANA_GREEN,
	output      logic [7:0]                  ANA_BLUE,
	output      logic                        ANA_OE,
	// sync pins
	output      logic                        LINE_SYNC_PIN,
	output      logic                        FRAME_SYNC_PIN,
	output      logic                        REFERENCE_SYNC_PIN,
	output      logic                        SYNC_OE,
	// pixel data pins
	output      logic [23:0]                 PIXEL_DATA_PINS,
	output      logic                        PIXEL_DATA_OE,
	// key pin
	output      logic                        KEY_MATCH_PIN,
	output      logic                        KEY_MATCH_OE,
	// internal consumers
	output      logic                        PIX_CLK_GATE,
	output      logic                        LAMP_SYNC,
	output      logic                        DISPLAY_SYNC_FLAG
);
	import dor_pkg::*;

	// ---------------------------------------------------------------
	// parameter check
	// ---------------------------------------------------------------
	if (ADDR_W < 5) begin : g_bad_aw
		$error("address width too small for register map");
	end

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  pck_sync;
		logic        pck_prev;
		logic        mix6_prev;
		logic [31:0] ctrl;
		logic [15:0] lim_red;
		logic [15:0] lim_green;
		logic [15:0] lim_blue;
		logic        flag;
		logic        key_act;
		logic        aw_ok;
		logic [7:0]  awaddr;
		logic        w_ok;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [23:0] ana;
		logic        ana_oe;
		logic [2:0]  sync;
		logic        sync_oe;
		logic [23:0] dpins;
		logic        d_oe;
		logic        key_pin;
		logic        key_oe;
		logic        gate;
		logic        lamp;
	} dor_state_s;

	dor_state_s r;
	dor_state_s next_r;

	dor_key_if kif ();
	dor_key_match u_key (
		.kif (kif.chk)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				m[8*i +: 8] = d[8*i +: 8];
			end
		end
		return m;
	endfunction : merge

	function automatic logic known(input logic [7:0] a);
		return (a == OFS_CTRL) || (a == OFS_KEY_RED) || (a == OFS_KEY_GREEN)
			|| (a == OFS_KEY_BLUE) || (a == OFS_STATUS);
	endfunction : known

	logic       pix_edge;
	logic       mix6_rise;
	logic       sgl;
	logic       twin;
	dor_fmt_e   fmt;
	logic       serial_fmt;
	logic       ana_drive;
	logic       data_hi_pix;
	logic [7:0] ar;
	logic [31:0] status;

	assign pix_edge    = r.pck_sync[1] & ~r.pck_prev;
	assign mix6_rise   = SYNC_MIX[MIX_FLAG] & ~r.mix6_prev;
	assign sgl         = r.ctrl[CTL_SGL_SCAN];
	assign twin        = r.ctrl[CTL_TWIN];
	assign fmt         = dor_fmt_e'(r.ctrl[CTL_FMT_LO +: 3]);
	assign serial_fmt  = (fmt >= FMT_SERIAL_9BIT) && (fmt <= FMT_SERIAL_24BIT);
	assign ana_drive   = sgl && ((fmt == FMT_ANALOG_PRIMARY) || (twin && serial_fmt));
	assign data_hi_pix = sgl && ((fmt == FMT_SERIAL_24BIT)
		|| ((fmt == FMT_ANALOG_PRIMARY) && twin));
	assign ar          = 8'(S_AXI_ARADDR);
	assign status      = {16'h0000, SYNC_MIX, 6'h00, r.key_act, r.flag};

	assign kif.pixel     = PIX_KEY_DATA;
	assign kif.cspace    = r.ctrl[CTL_CSPACE_LO +: 4];
	assign kif.lim_red   = r.lim_red;
	assign kif.lim_green = r.lim_green;
	assign kif.lim_blue  = r.lim_blue;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic wr;
		logic clr;
		wr     = 1'b0;
		clr    = 1'b0;
		next_r = r;
		// pixel clock from another domain, edge found after two stages
		next_r.pck_sync  = {r.pck_sync[0], PIX_CLK};
		next_r.pck_prev  = r.pck_sync[1];
		next_r.mix6_prev = SYNC_MIX[MIX_FLAG];

		// write address and data taken in either order
		if (S_AXI_AWVALID && !r.aw_ok) begin
			next_r.aw_ok  = 1'b1;
			next_r.awaddr = 8'(S_AXI_AWADDR);
		end
		if (S_AXI_WVALID && !r.w_ok) begin
			next_r.w_ok  = 1'b1;
			next_r.wdata = S_AXI_WDATA;
			next_r.wstrb = S_AXI_WSTRB;
		end
		if (r.bvalid && S_AXI_BREADY) begin
			next_r.bvalid = 1'b0;
		end
		if (r.aw_ok && r.w_ok && !r.bvalid) begin
			wr            = 1'b1;
			next_r.aw_ok  = 1'b0;
			next_r.w_ok   = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp  = known(r.awaddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (wr) begin
			unique case (r.awaddr)
				OFS_CTRL:      next_r.ctrl = merge(r.ctrl, r.wdata, r.wstrb);
				OFS_KEY_RED:   next_r.lim_red = 16'(merge({16'h0000, r.lim_red},
					r.wdata, r.wstrb));
				OFS_KEY_GREEN: next_r.lim_green = 16'(merge({16'h0000, r.lim_green},
					r.wdata, r.wstrb));
				OFS_KEY_BLUE:  next_r.lim_blue = 16'(merge({16'h0000, r.lim_blue},
					r.wdata, r.wstrb));
				OFS_STATUS:    clr = r.wstrb[0] & r.wdata[STS_FLAG];
				default:       clr = 1'b0;
			endcase
		end

		// flag set by mixer 6, set beats clear
		next_r.flag = (r.flag & ~clr) | mix6_rise;

		// read answered one cycle after the address is taken
		if (r.rvalid && S_AXI_RREADY) begin
			next_r.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && !r.rvalid) begin
			next_r.rvalid = 1'b1;
			next_r.rresp  = known(ar) ? RESP_OKAY : RESP_SLVERR;
			unique case (ar)
				OFS_CTRL:      next_r.rdata = r.ctrl;
				OFS_KEY_RED:   next_r.rdata = {16'h0000, r.lim_red};
				OFS_KEY_GREEN: next_r.rdata = {16'h0000, r.lim_green};
				OFS_KEY_BLUE:  next_r.rdata = {16'h0000, r.lim_blue};
				OFS_STATUS:    next_r.rdata = status;
				default:       next_r.rdata = 32'h0000_0000;
			endcase
		end

		// colour key, decided once per pixel clock
		if (pix_edge) begin
			if (!PIX_VISIBLE) begin
				next_r.key_act = 1'b0;
			end else if (PIX_COMPLETE) begin
				// per pixel update; leftmost complete pixel
				next_r.key_act = kif.match;
			end
			// no complete pixel keeps last result
		end
		next_r.key_pin = next_r.key_act ? r.ctrl[CTL_KEY_POL] : ~r.ctrl[CTL_KEY_POL];
		next_r.key_oe  = r.ctrl[CTL_KEY_OE];

		// analog pins, float unless both allow
		next_r.ana_oe = ana_drive & r.ctrl[CTL_DAC_OE];
		next_r.ana    = next_r.ana_oe ? {ANA_RED_IN, ANA_GREEN_IN, ANA_BLUE_IN} : 24'h000000;

		// sync pins pass mixer waveforms as they are
		next_r.sync    = SYNC_MIX[2:0];
		next_r.sync_oe = r.ctrl[CTL_SYNC_OE];
		next_r.d_oe    = r.ctrl[CTL_DATA_OE];

		// shared data bits carry mixers 3..7 unless pixels own them
		next_r.dpins = PIX_DATA;
		if (!data_hi_pix) begin
			next_r.dpins[23:DATA_SHARED_LO] = SYNC_MIX[MIX_GATE:MIX_DATA_LO];
		end

		next_r.gate = SYNC_MIX[MIX_GATE];
		next_r.lamp = SYNC_MIX[MIX_LAMP];
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			r           <= '0;
			r.ctrl      <= CTRL_RESET;
			r.lim_red   <= LIMIT_RESET;
			r.lim_green <= LIMIT_RESET;
			r.lim_blue  <= LIMIT_RESET;
			r.key_pin   <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign S_AXI_AWREADY      = !r.aw_ok;
	assign S_AXI_WREADY       = !r.w_ok;
	assign S_AXI_BVALID       = r.bvalid;
	assign S_AXI_BRESP        = r.bresp;
	assign S_AXI_ARREADY      = !r.rvalid;
	assign S_AXI_RVALID       = r.rvalid;
	assign S_AXI_RDATA        = r.rdata;
	assign S_AXI_RRESP        = r.rresp;
	assign ANA_RED            = r.ana[23:16];
	assign ANA_GREEN          = r.ana[15:8];
	assign ANA_BLUE           = r.ana[7:0];
	assign ANA_OE             = r.ana_oe;
	assign LINE_SYNC_PIN      = r.sync[0];
	assign FRAME_SYNC_PIN     = r.sync[1];
	assign REFERENCE_SYNC_PIN = r.sync[2];
	assign SYNC_OE            = r.sync_oe;
	assign PIXEL_DATA_PINS    = r.dpins;
	assign PIXEL_DATA_OE      = r.d_oe;
	assign KEY_MATCH_PIN      = r.key_pin;
	assign KEY_MATCH_OE       = r.key_oe;
	assign PIX_CLK_GATE       = r.gate;
	assign LAMP_SYNC          = r.lamp;
	assign DISPLAY_SYNC_FLAG  = r.flag;
endmodule : dor_output_stage

// File: hdl/dor_pkg.sv
package dor_pkg;
	// ---------------------------------------------------------------
	// bus geometry
	// ---------------------------------------------------------------
	localparam int          AXI_AW         = 8;
	localparam int          AXI_DW         = 32;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_KEY_RED    = 8'h04;
	localparam logic [7:0]  OFS_KEY_GREEN  = 8'h08;
	localparam logic [7:0]  OFS_KEY_BLUE   = 8'h0C;
	localparam logic [7:0]  OFS_STATUS     = 8'h10;
	// ---------------------------------------------------------------
	// control fields and reset values
	// ---------------------------------------------------------------
	localparam int          CTL_SGL_SCAN   = 0;
	localparam int          CTL_TWIN       = 1;
	localparam int          CTL_FMT_LO     = 4;
	localparam int          CTL_DAC_OE     = 7;
	localparam int          CTL_KEY_OE     = 8;
	localparam int          CTL_SYNC_OE    = 9;
	localparam int          CTL_DATA_OE    = 10;
	localparam int          CTL_KEY_POL    = 11;
	localparam int          CTL_CSPACE_LO  = 12;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
	localparam logic [15:0] LIMIT_RESET    = 16'hFF00;
	localparam int          STS_FLAG       = 0;
	localparam int          STS_KEY        = 1;
	localparam int          STS_MIX_LO     = 8;
	// ---------------------------------------------------------------
	// bit stream formats and colour spaces
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		FMT_ANALOG_PRIMARY = 3'h0,
		FMT_SERIAL_9BIT    = 3'h1,
		FMT_SERIAL_12BIT   = 3'h2,
		FMT_SERIAL_16BIT   = 3'h3,
		FMT_SERIAL_18BIT   = 3'h4,
		FMT_SERIAL_24BIT   = 3'h5,
		FMT_PARALLEL_A     = 3'h6,
		FMT_PARALLEL_B     = 3'h7
	} dor_fmt_e;
	typedef enum logic [3:0] {
		CS_RGB111 = 4'h0,
		CS_RGB222 = 4'h1,
		CS_RGB8BPP = 4'h2,
		CS_RGB333 = 4'h3,
		CS_RGB444 = 4'h4,
		CS_RGB555 = 4'h5,
		CS_RGB565 = 4'h6,
		CS_RGB666 = 4'h7,
		CS_RGB888 = 4'h8
	} dor_cspace_e;
	// mixer positions
	localparam int          MIX_LAMP       = 5;
	localparam int          MIX_FLAG       = 6;
	localparam int          MIX_GATE       = 7;
	localparam int          MIX_DATA_LO    = 3;
	localparam int          DATA_SHARED_LO = 19;
endpackage : dor_pkg

// File: tb/dor_display_model.sv
`timescale 1ns/10ps
module dor_display_model (
	// link clock toward the stage
	output logic pix_clk
);
	initial pix_clk = 1'b0;
	// -------------
	// pixel clock
	// -------------
	// runs only inside a frame and stands low between frames;
	// the 13 ns lead keeps its edges off the reference clock edges
	task automatic pulse(input int n);
		#13;
		repeat (n) begin
			#100 pix_clk = 1'b1;
			#100 pix_clk = 1'b0;
		end
	endtask : pulse
endmodule : dor_display_model

// File: tb/dor_output_stage_monitor.sv
`timescale 1ns/10ps
module dor_output_stage_monitor (
	// clock and reset
	input wire logic        REF_CLK,
	input wire logic        RST_N,
	// register bus
	input wire logic        S_AXI_AWVALID,
	input wire logic        S_AXI_AWREADY,
	input wire logic        S_AXI_WVALID,
	input wire logic        S_AXI_WREADY,
	input wire logic [1:0]  S_AXI_BRESP,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	// pins
	input wire logic [23:0] PIX_DATA,
	input wire logic [7:0]  SYNC_MIX,
	input wire logic [7:0]  ANA_RED,
	input wire logic        ANA_OE,
	input wire logic        LINE_SYNC_PIN,
	input wire logic        FRAME_SYNC_PIN,
	input wire logic        REFERENCE_SYNC_PIN,
	input wire logic [23:0] PIXEL_DATA_PINS,
	input wire logic        PIX_CLK_GATE,
	input wire logic        LAMP_SYNC,
	input wire logic        DISPLAY_SYNC_FLAG
);
	logic        up_q;
	logic [7:0]  mix_q;
	logic [18:0] dat_q;
	// ----------------
	// helper history
	// ----------------
	// up_q hides the first edge after reset, where history is stale
	always_ff @(posedge REF_CLK) begin
		up_q  <= RST_N;
		mix_q <= SYNC_MIX;
		dat_q <= PIX_DATA[18:0];
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	chk_sync_route:
		assert property (up_q |-> {REFERENCE_SYNC_PIN, FRAME_SYNC_PIN, LINE_SYNC_PIN}
			== mix_q[2:0]) else $error("sync pins differ from mixers");
	chk_internal_mix:
		assert property (up_q |-> PIX_CLK_GATE == mix_q[7] && LAMP_SYNC == mix_q[5])
		else $error("internal mixer lines differ");
	chk_data_low:
		assert property (up_q |-> PIXEL_DATA_PINS[18:0] == dat_q)
		else $error("low data pins differ from pixel data");
	chk_flag_set:
		assert property ($rose(SYNC_MIX[6]) |-> ##[1:3] DISPLAY_SYNC_FLAG)
		else $error("sync flag not set by mixer rise");
	chk_ana_float:
		assert property (!ANA_OE |-> ANA_RED == 8'h00)
		else $error("analog code present while undriven");
	chk_write_answer:
		assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
			|-> ##[1:2] S_AXI_BVALID) else $error("write response missing");
	chk_read_answer:
		assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read response missing");
	chk_resp_hold:
		assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped early");
	chk_read_refuse:
		assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read address taken while busy");
	cover property (S_AXI_BVALID && S_AXI_BREADY);
	cover property (S_AXI_RVALID && S_AXI_RREADY);
	cover property ($rose(DISPLAY_SYNC_FLAG));
endmodule : dor_output_stage_monitor
bind dor_output_stage dor_output_stage_monitor i_dor_output_stage_monitor (.*);

// File: tb/tb_dor_output_stage.sv
`timescale 1ns/10ps
module tb_dor_output_stage;
	import dor_pkg::*;
	logic        clk, rst_n, awv, wv, brd, arv, rrd, vis, cm, pol;
	logic [3:0]  stb;
	logic [7:0]  awa, ara, red, grn, blu, mix, ao_r, ao_g, ao_b;
	logic [31:0] wd, rdat;
	logic [23:0] pd, kd, dp;
	logic [1:0]  br, rr;
	logic        pclk, awr, wrd, bv, arr, rv, aoe, lsp, fsp, rsp, soe, doe, kp, koe, gate, lamp, flg;
	int          mismatches, checks_done;
	// channel positions for colour spaces 0 to 8; blue always starts at bit 0
	int          rl[9] = '{2, 4, 5, 6, 8, 11, 11, 12, 16};
	int          gl[9] = '{1, 2, 2, 3, 4, 6, 5, 6, 8};
	int          rw[9] = '{1, 2, 3, 3, 4, 5, 5, 6, 8};
	int          gw[9] = '{1, 2, 3, 3, 4, 5, 6, 6, 8};
	int          bw[9] = '{1, 2, 2, 3, 4, 5, 5, 6, 8};
	dor_display_model i_dor_display_model (.pix_clk(pclk));
	dor_output_stage i_dor_output_stage (
		.REF_CLK(clk), .RST_N(rst_n),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(stb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
		.S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(brd),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrd),
		.PIX_CLK(pclk), .PIX_DATA(pd), .PIX_KEY_DATA(kd), .PIX_VISIBLE(vis),
		.PIX_COMPLETE(cm), .ANA_RED_IN(red), .ANA_GREEN_IN(grn), .ANA_BLUE_IN(blu),
		.SYNC_MIX(mix), .ANA_RED(ao_r), .ANA_GREEN(ao_g), .ANA_BLUE(ao_b), .ANA_OE(aoe),
		.LINE_SYNC_PIN(lsp), .FRAME_SYNC_PIN(fsp), .REFERENCE_SYNC_PIN(rsp), .SYNC_OE(soe),
		.PIXEL_DATA_PINS(dp), .PIXEL_DATA_OE(doe), .KEY_MATCH_PIN(kp), .KEY_MATCH_OE(koe),
		.PIX_CLK_GATE(gate), .LAMP_SYNC(lamp), .DISPLAY_SYNC_FLAG(flg)
	);
	// ---------------
	// helper tasks
	// ---------------
	task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h instead of %h", $time, got, exp);
		end
	endtask : cmp_v
	task automatic stop_test();
		if (mismatches == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic hang(input int n);
		if (n >= 50) begin
			mismatches++;
			stop_test();
		end
	endtask : hang
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n = 0;
		bit ad = 0;
		bit dd = 0;
		awa <= a;
		wd <= d;
		{awv, wv} <= 2'h3;
		while (!(ad && dd) && n < 50) begin
			@(posedge clk);
			n++;
			if (awr && !ad) begin
				ad = 1;
				awv <= 1'b0;
			end
			if (wrd && !dd) begin
				dd = 1;
				wv <= 1'b0;
			end
		end
		while (!bv && n < 50) begin
			@(posedge clk);
			n++;
		end
		hang(n);
		brd <= 1'b1;
		@(posedge clk);
		r = br;
		brd <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n = 0;
		ara <= a;
		arv <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (!arr && n < 50);
		arv <= 1'b0;
		while (!rv && n < 50) begin
			@(posedge clk);
			n++;
		end
		hang(n);
		rrd <= 1'b1;
		@(posedge clk);
		d = rdat;
		r = rr;
		rrd <= 1'b0;
	endtask : rd
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#1000000;
		mismatches++;
		stop_test();
	end
	// ---------------
	// main sequence
	// ---------------
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [2:0]  f;
		int          k, w, m, lo, hi, v, px;
		bit          hit, ka, sg, tw, e, ds;
		mismatches = 0;
		checks_done = 0;
		rst_n = 1'b0;
		stb = 4'hF;
		{awv, wv, brd, arv, rrd, vis, cm, pol} = '0;
		{awa, ara, red, grn, blu, mix, wd, pd, kd} = '0;
		void'($urandom(74405));
		tick(20);
		rst_n <= 1'b1;
		tick(1);
		cmp_v({aoe, soe, doe, koe, kp}, 5'h01);
		rd(OFS_KEY_BLUE, d, r);
		cmp_v(d, LIMIT_RESET);
		cmp_v(r, RESP_OKAY);
		rd(8'h14, d, r);
		cmp_v(d, 32'h0);
		cmp_v(r, RESP_SLVERR);
		wr(8'h14, 32'hFFFF_FFFF, r);
		cmp_v(r, RESP_SLVERR);
		// every scan, format and converter enable combination; sync, data and key enables follow c[1], c[0], c[2]
		for (int c = 0; c < 64; c++) begin
			sg = c[0];
			tw = c[1];
			f = c[4:2];
			wr(OFS_CTRL, {16'h0, 4'h8, 1'b0, c[0], c[1], c[2], c[5], f, 2'h0, tw, sg}, r);
			mix <= 8'($urandom);
			pd <= 24'($urandom);
			{red, grn, blu} <= 24'($urandom);
			tick(3);
			e = sg && (f == 3'h0 || tw && f >= 3'h1 && f <= 3'h5) && c[5];
			ds = sg && (f == 3'h5 || f == 3'h0 && tw);
			cmp_v(aoe, e);
			cmp_v({ao_r, ao_g, ao_b}, e ? {red, grn, blu} : 24'h0);
			cmp_v({rsp, fsp, lsp}, mix[2:0]);
			cmp_v({gate, lamp}, {mix[7], mix[5]});
			cmp_v(dp, ds ? pd : {mix[7:3], pd[18:0]});
			cmp_v({soe, doe, koe}, {c[1], c[0], c[2]});
		end
		// key over randomly chosen colour spaces, boundary values and inverted limits
		ka = 0;
		for (int i = 0; i < 40; i++) begin
			k = $urandom % 9;
			pol = 1'($urandom);
			px = 0;
			hit = 1;
			for (int ch = 0; ch < 3; ch++) begin
				w = (ch == 0) ? rw[k] : (ch == 1) ? gw[k] : bw[k];
				m = (1 << w) - 1;
				lo = $urandom & m;
				hi = $urandom & m;
				case ($urandom % 3)
					0: v = lo;
					1: v = hi;
					default: v = $urandom & m;
				endcase
				hit = hit && lo <= v && v <= hi;
				px = px | (v << (ch == 0 ? rl[k] : ch == 1 ? gl[k] : 0));
				wr(OFS_KEY_RED + 8'(4 * ch), {16'h0, 8'(hi), 8'(lo)}, r);
			end
			wr(OFS_CTRL, {16'h0, 4'(k), pol, 3'h1, 8'h00}, r);
			vis <= ($urandom % 4) != 0;
			cm <= ($urandom % 4) != 0;
			kd <= 24'(px);
			tick(1);
			i_dor_display_model.pulse(1);
			if (!vis)
				ka = 0;
			else if (cm)
				ka = hit;
			tick(3);
			cmp_v(kp, ka ? pol : !pol);
			cmp_v(koe, 1'b1);
		end
		rd(OFS_CTRL, d, r);
		cmp_v(d, {16'h0, 4'(k), pol, 3'h1, 8'h00});
		// sticky flag from a rising mixer 6; status also shows live mixers
		mix <= 8'h00;
		tick(3);
		wr(OFS_STATUS, 32'h1, r);
		tick(2);
		cmp_v(flg, 1'b0);
		mix <= 8'h40;
		tick(3);
		mix <= 8'hA5;
		tick(3);
		cmp_v(flg, 1'b1);
		rd(OFS_STATUS, d, r);
		cmp_v(d, {16'h0, 8'hA5, 6'h00, ka, 1'b1});
		wr(OFS_STATUS, 32'h1, r);
		tick(2);
		cmp_v(flg, 1'b0);
		stop_test();
	end
endmodule : tb_dor_output_stage
